//--- design/tape_fmt_pkg.sv
package tape_fmt_pkg;
// Function
// - one selected transport of eight at once
// - four tracks: mark plus three data
// - five zones, data area whole words
// - one-word block number at both ends
// - block-number functions use leading number only
// - data functions also process parity areas
// - skip sync areas, allow function change
// - all-area functions process every zone but the end zone
// - read and write, either direction
// - twelve frames pack into one word
// - reverse differs only in frame order within a word
// - mark formatting also writes timing track
// - word rate follows the timing track
// - first and last outer numbers unprocessed
// - write ones, data, then parity
// - read checks parity, sets error flag
// - two-frame bytes, high digit first forward
// - ignore space codes leaving end zone
// - even parity per byte bit position
// - parity in two frames, rest zeros
// - mark track tells zone under heads
// - standard tape 578 blocks, 128 words
// - three-bit function code selects operation
// - write functions raise data request

localparam int WORD_W = 36;
localparam int FRAME_W = 3;
localparam int BYTE_W = 6;
localparam int NUM_UNITS = 8;
localparam int UNIT_W = 3;
localparam int MARK_W = 6;
localparam int FRAMES_PER_WORD = 12;
localparam logic [3:0] FIRST_FRAME = 4'h0;
localparam logic [3:0] LAST_FRAME = 4'hb;
localparam logic [3:0] PAR_CHAR_FRAMES = 4'h2;
localparam logic [5:0] FRAME_SHIFT = 6'h3;
localparam logic [5:0] MARK_TOP = 6'h23;
localparam logic [NUM_UNITS-1:0] UNIT_ONE = 8'h01;

// function codes
localparam int WR_BIT = 2;
localparam logic [2:0] FN_NONE = 3'h0;
localparam logic [2:0] FN_RD_ALL = 3'h1;
localparam logic [2:0] FN_RD_BN = 3'h2;
localparam logic [2:0] FN_RD_DATA = 3'h3;
localparam logic [2:0] FN_WR_MARK = 3'h4;
localparam logic [2:0] FN_WR_ALL = 3'h5;
localparam logic [2:0] FN_WR_BN = 3'h6;
localparam logic [2:0] FN_WR_DATA = 3'h7;

// zone mark codes, six mark bits closing the previous word
localparam logic [MARK_W-1:0] CODE_END = 6'h15;
localparam logic [MARK_W-1:0] CODE_BN = 6'h26;
localparam logic [MARK_W-1:0] CODE_SYNC = 6'h08;
localparam logic [MARK_W-1:0] CODE_PAR = 6'h3b;
localparam logic [MARK_W-1:0] CODE_DATA = 6'h32;

localparam logic [FRAME_W-1:0] FRAME_ONES = 3'h7;
localparam logic [FRAME_W-1:0] FRAME_ZERO = 3'h0;
localparam logic [BYTE_W-1:0] BYTE_ZERO = 6'h00;

// block geometry
localparam int MIN_DATA_FRAMES = 24;
localparam int MIN_DATA_WORDS = MIN_DATA_FRAMES / FRAMES_PER_WORD;
localparam int STD_BLOCKS = 578;
localparam logic [11:0] STD_LAST_BLOCK = 12'h241;
localparam int STD_DATA_WORDS = 128;
localparam int DCNT_W = $clog2(STD_DATA_WORDS) + 1;

// word timing
localparam int CLK_PERIOD_NS = 100;
localparam int WORD_NOM_NS = 400;
localparam int WORD_MIN_NS = 320;
localparam int WORD_MAX_NS = 480;
localparam int WORD_MIN_CYC =
    (WORD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

typedef enum logic [4:0] {
    Z_END = 5'h01,
    Z_BN = 5'h02,
    Z_SYNC = 5'h04,
    Z_PAR = 5'h08,
    Z_DATA = 5'h10
} zone_t;

endpackage : tape_fmt_pkg

//--- design/tape_format_ctrl.sv
`timescale 1ns/1ps
module tape_format_ctrl
    import tape_fmt_pkg::*;
(
    input wire logic clk, // host clock
    input wire logic rst, // async reset, high
    input wire logic tapeClk, // timing track clock
    input wire logic cmdLoad, // command strobe
    input wire logic [2:0] cmdFunc, // function code
    input wire logic cmdRev, // reverse motion
    input wire logic [UNIT_W-1:0] cmdUnit, // transport number
    input wire logic [WORD_W-1:0] wrWord, // word to write
    input wire logic wrValid, // write word offered
    output logic wrReady, // write buffer empty
    output logic [WORD_W-1:0] rdWord, // word read
    output logic rdValid, // read word pulse
    output logic dataReq, // data request flag
    output logic parityErr, // parity error flag
    output logic markErr, // mark track error flag
    output logic [NUM_UNITS-1:0] unitSel, // transport select
    input wire logic [NUM_UNITS-1:0] tapeMarkIn, // mark heads
    input wire logic [NUM_UNITS*FRAME_W-1:0] tapeDataIn, // data heads
    output logic markOut, // mark write bit
    output logic markOe, // mark write enable
    output logic [FRAME_W-1:0] dataOut, // data write frame
    output logic dataOe, // data write enable
    output logic timingOut // timing track write
);

    // ---------------- host clock domain ----------------
    logic [2:0] funcR; // held function
    logic revR; // held direction
    logic [UNIT_W-1:0] unitR; // held unit
    logic cmdTglR; // command event toggle
    logic [NUM_UNITS-1:0] unitHot; // decoded unit
    logic [NUM_UNITS-1:0] unitSel_r;
    logic [FRAME_W-1:0] dataArr [NUM_UNITS]; // per unit heads

    // per transport decode and head split
    genvar gi;
    for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
        assign unitHot[gi] = (unitR == UNIT_W'(gi));
        assign dataArr[gi] = tapeDataIn[gi*FRAME_W +: FRAME_W];
    end

    // command register; values stay put until the next load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            funcR <= FN_NONE;
            revR <= 1'b0;
            unitR <= '0;
            cmdTglR <= 1'b0;
        end else if (cmdLoad) begin
            funcR <= cmdFunc;
            revR <= cmdRev;
            unitR <= cmdUnit;
            cmdTglR <= ~cmdTglR;
        end
    end

    // one transport selected at a time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) unitSel_r <= '0;
        else unitSel_r <= unitHot;
    end

    // write word hand-off toward the tape side
    logic [WORD_W-1:0] wrBufR; // stable while not empty
    logic wrEmptyR; // buffer free
    logic wrTglR; // word event toggle
    logic ackTglL; // tape side took the word
    logic ackS1, ackS2, ackSeenR; // ack synchroniser
    logic dataReq_r;
    wire wrTake = wrValid && wrEmptyR;
    wire ackEdge = ackS2 ^ ackSeenR;
    wire reqSet = (cmdLoad && cmdFunc[WR_BIT]) ||
        (ackEdge && funcR[WR_BIT]);
    wire reqClr = wrTake || (cmdLoad && !cmdFunc[WR_BIT]);

    // buffer the offered word and flag it to the link
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrBufR <= '0;
            wrEmptyR <= 1'b1;
            wrTglR <= 1'b0;
        end else if (wrTake) begin
            wrBufR <= wrWord;
            wrEmptyR <= 1'b0;
            wrTglR <= ~wrTglR;
        end else if (ackEdge) begin
            wrEmptyR <= 1'b1;
        end
    end

    // ack toggle synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackS1 <= 1'b0;
            ackS2 <= 1'b0;
            ackSeenR <= 1'b0;
        end else begin
            ackS1 <= ackTglL;
            ackS2 <= ackS1;
            ackSeenR <= ackS2;
        end
    end

    // data request: a new request wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) dataReq_r <= 1'b0;
        else if (reqSet) dataReq_r <= 1'b1;
        else if (reqClr) dataReq_r <= 1'b0;
    end

    // read word and flags from the link
    logic [WORD_W-1:0] rdWordL; // held by link until next word
    logic rdTglL; // read event toggle
    logic parErrL, markErrL; // link side flags
    logic rdS1, rdS2, rdSeenR;
    logic peS1, peS2, meS1, meS2;
    logic [WORD_W-1:0] rdWord_r;
    logic rdValid_r;
    wire rdEdge = rdS2 ^ rdSeenR;

    // synchronisers; the word is stable a whole word past its toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdS1 <= 1'b0;
            rdS2 <= 1'b0;
            rdSeenR <= 1'b0;
            peS1 <= 1'b0;
            peS2 <= 1'b0;
            meS1 <= 1'b0;
            meS2 <= 1'b0;
        end else begin
            rdS1 <= rdTglL;
            rdS2 <= rdS1;
            rdSeenR <= rdS2;
            peS1 <= parErrL;
            peS2 <= peS1;
            meS1 <= markErrL;
            meS2 <= meS1;
        end
    end

    // word hand-over to the host
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdWord_r <= '0;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= rdEdge;
            if (rdEdge) rdWord_r <= rdWordL;
        end
    end

    // ---------------- link (timing track) domain ----------------
    // every link edge is one frame; the word rate thus follows
    // the timing track in both directions
    logic cmdS1, cmdS2, cmdSeenL; // command synchroniser
    logic wrS1, wrS2, wrSeenL; // word synchroniser
    logic [2:0] funcL;
    logic revL;
    logic [UNIT_W-1:0] unitL;
    logic [WORD_W-1:0] holdL; // next word to write
    wire cmdEdgeL = cmdS2 ^ cmdSeenL;
    wire wrEdgeL = wrS2 ^ wrSeenL;

    // event synchronisers on the tape clock
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            cmdS1 <= 1'b0;
            cmdS2 <= 1'b0;
            cmdSeenL <= 1'b0;
            wrS1 <= 1'b0;
            wrS2 <= 1'b0;
            wrSeenL <= 1'b0;
        end else begin
            cmdS1 <= cmdTglR;
            cmdS2 <= cmdS1;
            cmdSeenL <= cmdS2;
            wrS1 <= wrTglR;
            wrS2 <= wrS1;
            wrSeenL <= wrS2;
        end
    end

    // command and write word capture; the host side holds both
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            funcL <= FN_NONE;
            revL <= 1'b0;
            unitL <= '0;
            holdL <= '0;
            ackTglL <= 1'b0;
        end else begin
            if (cmdEdgeL) begin
                funcL <= funcR;
                revL <= revR;
                unitL <= unitR;
            end
            if (wrEdgeL) begin
                holdL <= wrBufR;
                ackTglL <= ~ackTglL;
            end
        end
    end

    // only the selected transport's heads are looked at
    wire markSel = tapeMarkIn[unitL];
    wire [FRAME_W-1:0] dataSel = dataArr[unitL];

    logic [3:0] frameCntL; // frame within word
    logic lockedL; // word framing found
    zone_t zoneL; // zone of current word
    logic [MARK_W-1:0] markWinL; // recent mark bits
    logic pastDataL; // data area of block seen
    logic afterEndL; // leaving an end zone
    logic [DCNT_W-1:0] dataCntL; // words in data area
    logic [BYTE_W-1:0] parAccL; // running parity
    logic [WORD_W-1:0] wordAccL; // word being read
    logic [WORD_W-1:0] shiftL; // word being written

    // zone recognition from the mark track
    wire [MARK_W-1:0] markWinNxt = {markWinL[MARK_W-2:0], markSel};
    wire hitEnd = (markWinNxt == CODE_END);
    wire hitBn = (markWinNxt == CODE_BN);
    wire hitSync = (markWinNxt == CODE_SYNC);
    wire hitPar = (markWinNxt == CODE_PAR);
    wire hitData = (markWinNxt == CODE_DATA);
    wire hitAny = hitEnd | hitBn | hitSync | hitPar | hitData;
    wire zone_t zoneHit = hitEnd ? Z_END : hitBn ? Z_BN :
        hitSync ? Z_SYNC : hitPar ? Z_PAR : Z_DATA;

    // function decode
    wire wordEnd = (frameCntL == LAST_FRAME);
    wire isWrite = funcL[WR_BIT];
    wire markMode = (funcL == FN_WR_MARK);
    wire isBnFn = (funcL == FN_RD_BN) || (funcL == FN_WR_BN);
    wire isDataFn = (funcL == FN_RD_DATA) || (funcL == FN_WR_DATA);
    wire isAllFn = (funcL == FN_RD_ALL) || (funcL == FN_WR_ALL);

    // the leading number is the first of a block met; numbers
    // seen right after leaving an end zone are space codes
    wire leadBn = (zoneL == Z_BN) && !pastDataL &&
        !afterEndL;
    wire inPar = (zoneL == Z_PAR);
    wire leadPar = inPar && !pastDataL;
    wire trailPar = inPar && pastDataL;
    wire procPar = lockedL && inPar && (isDataFn || isAllFn);
    wire procUser = lockedL && ((isBnFn && leadBn) ||
        (isDataFn && zoneL == Z_DATA) ||
        (isAllFn && zoneL != Z_END && !inPar));
    wire procFrame = procPar || procUser;

    // digit position: forward meets the high digit first
    wire [3:0] digit = revL ? frameCntL :
        (LAST_FRAME - frameCntL);
    wire [5:0] shAmt = {2'h0, digit} * FRAME_SHIFT;
    wire hiHalf = digit[0]; // odd digit is high half of byte
    wire [WORD_W-1:0] placed =
        {{(WORD_W-FRAME_W){1'b0}}, dataSel} << shAmt;
    wire [WORD_W-1:0] wordAccNxt =
        ((frameCntL == FIRST_FRAME) ? '0 : wordAccL) | placed;

    // write source: the hold word is taken at a word's first frame
    wire holdTake = isWrite && (frameCntL == FIRST_FRAME) &&
        (markMode || procUser);
    wire [WORD_W-1:0] wrSrc = holdTake ? holdL : shiftL;
    wire [WORD_W-1:0] wrShifted = wrSrc >> shAmt;
    wire [FRAME_W-1:0] parFrame = (frameCntL < PAR_CHAR_FRAMES) ?
        (hiHalf ? parAccL[BYTE_W-1:FRAME_W] :
        parAccL[FRAME_W-1:0]) : FRAME_ZERO;
    wire [FRAME_W-1:0] outFrame = leadPar ? FRAME_ONES :
        trailPar ? parFrame : wrShifted[FRAME_W-1:0];
    wire [FRAME_W-1:0] curFrame = isWrite ? outFrame : dataSel;

    // per bit even parity over both parity areas and the data
    wire [BYTE_W-1:0] parContrib = hiHalf ?
        {curFrame, FRAME_ZERO} : {FRAME_ZERO, curFrame};
    wire [BYTE_W-1:0] parAccNxt =
        ((leadPar && frameCntL == FIRST_FRAME) ? BYTE_ZERO :
        parAccL) ^ parContrib;
    wire parBad = !isWrite && procPar && trailPar && wordEnd &&
        (parAccNxt != BYTE_ZERO);
    wire shortBlk = lockedL && wordEnd && (zoneL == Z_DATA) &&
        (zoneHit != Z_DATA) &&
        (dataCntL < DCNT_W'(MIN_DATA_WORDS - 1));
    wire markBad = !markMode && lockedL && wordEnd && !hitAny;

    // framing: hunt for a code, then check it once per word
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            markWinL <= '0;
            frameCntL <= FIRST_FRAME;
            lockedL <= 1'b0;
            zoneL <= Z_END;
        end else begin
            markWinL <= markWinNxt;
            if (markMode || lockedL) begin
                frameCntL <= wordEnd ? FIRST_FRAME :
                    frameCntL + 4'h1;
            end else begin
                frameCntL <= FIRST_FRAME;
            end
            if (markMode) begin
                lockedL <= 1'b0;
            end else if (!lockedL || wordEnd) begin
                lockedL <= hitAny;
                if (hitAny) zoneL <= zoneHit;
            end
        end
    end

    // block position: which end is leading, end zone departure
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            pastDataL <= 1'b0;
            afterEndL <= 1'b0;
            dataCntL <= '0;
        end else if (lockedL && wordEnd) begin
            if (zoneL == Z_DATA) pastDataL <= 1'b1;
            else if (zoneL == Z_BN || zoneL == Z_END)
                pastDataL <= 1'b0;
            if (zoneL == Z_END) afterEndL <= 1'b1;
            else if (zoneL != Z_BN) afterEndL <= 1'b0;
            // sized to hold a standard block's data area
            if (zoneL == Z_DATA) dataCntL <= dataCntL + 1'b1;
            else dataCntL <= '0;
        end
    end

    // word assembly, parity and read hand-over
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            wordAccL <= '0;
            shiftL <= '0;
            parAccL <= BYTE_ZERO;
            rdWordL <= '0;
            rdTglL <= 1'b0;
        end else begin
            wordAccL <= wordAccNxt;
            if (holdTake) shiftL <= holdL;
            if (procPar) parAccL <= parAccNxt;
            else if (procUser && zoneL == Z_DATA)
                parAccL <= parAccNxt;
            if (!isWrite && procUser && wordEnd) begin
                rdWordL <= wordAccNxt;
                rdTglL <= ~rdTglL;
            end
        end
    end

    // error flags: a new error wins over a command clear
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            parErrL <= 1'b0;
            markErrL <= 1'b0;
        end else begin
            if (parBad) parErrL <= 1'b1;
            else if (cmdEdgeL) parErrL <= 1'b0;
            if (markBad || shortBlk) markErrL <= 1'b1;
            else if (cmdEdgeL) markErrL <= 1'b0;
        end
    end

    // tape write drivers, one frame behind the frame counter
    logic markOut_r, markOe_r, dataOe_r, timingOut_r;
    logic [FRAME_W-1:0] dataOut_r;
    always_ff @(posedge tapeClk or posedge rst) begin
        if (rst) begin
            markOut_r <= 1'b0;
            markOe_r <= 1'b0;
            dataOut_r <= FRAME_ZERO;
            dataOe_r <= 1'b0;
            timingOut_r <= 1'b0;
        end else begin
            markOut_r <= markMode && wrSrc[MARK_TOP - frameCntL];
            markOe_r <= markMode;
            timingOut_r <= markMode && !timingOut_r;
            dataOut_r <= markMode ? FRAME_ZERO : outFrame;
            dataOe_r <= isWrite && (markMode || procFrame);
        end
    end

    assign wrReady = wrEmptyR;
    assign rdWord = rdWord_r;
    assign rdValid = rdValid_r;
    assign dataReq = dataReq_r;
    assign parityErr = peS2;
    assign markErr = meS2;
    assign unitSel = unitSel_r;
    assign markOut = markOut_r;
    assign markOe = markOe_r;
    assign dataOut = dataOut_r;
    assign dataOe = dataOe_r;
    assign timingOut = timingOut_r;

    // ---------------- checks ----------------
    property p_unit_sel;
        @(posedge clk) disable iff (rst)
        cmdLoad |-> ##2 (unitSel_r == (UNIT_ONE << $past(cmdUnit, 2)));
    endproperty
    a_unit_sel: assert property (p_unit_sel)
        else $error("unit select wrong");

    property p_req;
        @(posedge clk) disable iff (rst)
        (cmdLoad && cmdFunc[WR_BIT]) |=> dataReq_r;
    endproperty
    a_req: assert property (p_req)
        else $error("write start gave no data request");

    property p_rate;
        @(posedge clk) disable iff (rst)
        rdValid_r |=> !rdValid_r [*3];
    endproperty
    a_rate: assert property (p_rate)
        else $error("read words closer than word time");

    property p_lead_ones;
        @(posedge tapeClk) disable iff (rst)
        (isWrite && procPar && leadPar) |=>
            (dataOut_r == FRAME_ONES) && dataOe_r;
    endproperty
    a_lead_ones: assert property (p_lead_ones)
        else $error("leading parity not ones");

    property p_trail_zero;
        @(posedge tapeClk) disable iff (rst)
        (isWrite && procPar && trailPar &&
            frameCntL >= PAR_CHAR_FRAMES) |=> (dataOut_r == FRAME_ZERO);
    endproperty
    a_trail_zero: assert property (p_trail_zero)
        else $error("trailing parity fill not zero");

    property p_par_err;
        @(posedge tapeClk) disable iff (rst)
        parBad |=> parErrL;
    endproperty
    a_par_err: assert property (p_par_err)
        else $error("parity error not flagged");

    property p_bn_lead;
        @(posedge tapeClk) disable iff (rst)
        (isBnFn && !isWrite && wordEnd && !(lockedL && leadBn))
            |=> $stable(rdTglL);
    endproperty
    a_bn_lead: assert property (p_bn_lead)
        else $error("non-leading block number read");

    property p_fwd_msd;
        @(posedge tapeClk) disable iff (rst)
        (!isWrite && procUser && wordEnd && !revL) |=>
            (rdWordL[WORD_W-1 -: FRAME_W] == $past(dataSel, 12));
    endproperty
    a_fwd_msd: assert property (p_fwd_msd)
        else $error("forward first frame not high digit");

    property p_rev_lsd;
        @(posedge tapeClk) disable iff (rst)
        (!isWrite && procUser && wordEnd && revL) |=>
            (rdWordL[FRAME_W-1:0] == $past(dataSel, 12));
    endproperty
    a_rev_lsd: assert property (p_rev_lsd)
        else $error("reverse first frame not low digit");

    property p_sync_skip;
        @(posedge tapeClk) disable iff (rst)
        (lockedL && zoneL == Z_SYNC && (isBnFn || isDataFn))
            |=> !dataOe_r;
    endproperty
    a_sync_skip: assert property (p_sync_skip)
        else $error("sync area written");

    property p_timing;
        @(posedge tapeClk) disable iff (rst)
        markMode |=> (timingOut_r != $past(timingOut_r));
    endproperty
    a_timing: assert property (p_timing)
        else $error("timing track not toggling");

    c_rd_word: cover property (@(posedge clk) disable iff (rst)
        rdValid_r);
    c_par_err: cover property (@(posedge clk) disable iff (rst)
        $rose(peS2));
    c_lead_par: cover property (@(posedge tapeClk) disable iff (rst)
        isWrite && procPar && leadPar);
    c_mark: cover property (@(posedge tapeClk) disable iff (rst)
        markMode && wordEnd);

endmodule : tape_format_ctrl

//--- sim/tape_transport_model.sv
`timescale 1ns/1ps
module tape_transport_model
    import tape_fmt_pkg::*;
(
    output logic tapeClk, // timing track, runs only in frames
    output logic [NUM_UNITS-1:0] tapeMarkIn, // mark heads
    output logic [NUM_UNITS*FRAME_W-1:0] tapeDataIn // data heads
);
    // clock stands low until a word is played
    initial begin
        tapeClk = 1'b0;
        tapeMarkIn = '0;
        tapeDataIn = '0;
    end

    // one word, data changes on the falling timing edge
    task automatic play_word(input logic [UNIT_W-1:0] unit,
        input logic [11:0] marks, input logic [WORD_W-1:0] word,
        input logic rev);
        logic [NUM_UNITS-1:0] mk;
        logic [NUM_UNITS*FRAME_W-1:0] dt;
        int k;
        int d;
        for (k = 0; k < 12; k++) begin
            // reverse motion meets the low digit first
            d = rev ? k : 11 - k;
            // unselected units see the inverse, never a copy
            mk = {NUM_UNITS{~marks[11-k]}};
            mk[unit] = marks[11-k];
            dt = {NUM_UNITS{~word[3*d +: 3]}};
            dt[3*unit +: 3] = word[3*d +: 3];
            tapeMarkIn = mk;
            tapeDataIn = dt;
            #80 tapeClk = 1'b1;
            #80 tapeClk = 1'b0;
        end
    endtask : play_word
endmodule : tape_transport_model

//--- sim/tb_tape_format_ctrl.sv
`timescale 1ns/1ps
module tb_tape_format_ctrl
    import tape_fmt_pkg::*;
;
    localparam logic [WORD_W-1:0] D0 = 36'h123456789; // first data word
    localparam logic [WORD_W-1:0] D1 = 36'hfedcba987; // second data word
    logic clk, rst, tapeClk, cmdLoad, cmdRev, wrValid, wrReady, rdValid;
    logic dataReq, parityErr, markErr, markOut, markOe, dataOe, timingOut;
    logic [2:0] cmdFunc; // function code
    logic [UNIT_W-1:0] cmdUnit; // transport number
    logic [WORD_W-1:0] wrWord, rdWord;
    logic [NUM_UNITS-1:0] unitSel, tapeMarkIn;
    logic [NUM_UNITS*FRAME_W-1:0] tapeDataIn;
    logic [FRAME_W-1:0] dataOut;
    logic [WORD_W-1:0] got[$]; // words seen on the read port
    int oeFrames = 0; // written frames, counted a frame late
    int tmgRise = 0; // timing track rising edges
    int errors = 0;
    int checksDone = 0;

    tape_format_ctrl tape_format_ctrl_inst (.clk, .rst, .tapeClk, .cmdLoad,
        .cmdFunc, .cmdRev, .cmdUnit, .wrWord, .wrValid, .wrReady, .rdWord,
        .rdValid, .dataReq, .parityErr, .markErr, .unitSel, .tapeMarkIn,
        .tapeDataIn, .markOut, .markOe, .dataOut, .dataOe, .timingOut);
    tape_transport_model tape_transport_model_inst (.tapeClk, .tapeMarkIn,
        .tapeDataIn);

    // host clock, 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // read pulses stand one cycle, so catch each at the edge
    always @(posedge clk) begin
        if (rdValid === 1'b1) got.push_back(rdWord);
    end

    // write enables and timing edges seen on the link side
    always @(posedge tapeClk) begin
        if (dataOe === 1'b1) oeFrames++;
    end
    always @(posedge timingOut) tmgRise++;

    task automatic check(input string what, input logic [WORD_W-1:0] exp,
        input logic [WORD_W-1:0] seen);
        checksDone++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        if (errors == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // one-cycle command strobe, launched off the falling edge
    task automatic send_cmd(input logic [2:0] f, input logic [2:0] u,
        input logic r);
        @(negedge clk);
        cmdFunc = f;
        cmdUnit = u;
        cmdRev = r;
        cmdLoad = 1'b1;
        @(negedge clk);
        cmdLoad = 1'b0;
    endtask : send_cmd

    // write command raises request, selects unit, takes a word
    task automatic t_write;
        send_cmd(FN_WR_DATA, 3'h5, 1'b0);
        @(negedge clk);
        check("dataReq", 36'h1, dataReq);
        @(negedge clk);
        check("unitSel", 36'(UNIT_ONE << 5), unitSel);
        wrValid = 1'b1;
        @(negedge clk);
        wrValid = 1'b0;
        check("wrReady", 36'h0, wrReady);
        // blank word spaces this command from the next one
        tape_transport_model_inst.play_word(3'h5, 12'h000, 36'h0, 1'b0);
        check("wrReady", 36'h1, wrReady);
        check("dataReq", 36'h1, dataReq);
    endtask : t_write

    // seven-word block on unit 3: lead-in word, sync, parity, two data, parity, sync
    task automatic play_block(input logic bad, input logic rev);
        logic [WORD_W-1:0] w[7];
        logic [5:0] nx[7];
        logic [5:0] par;
        int i;
        par = 6'h00;
        for (i = 0; i < 6; i++) par ^= D0[6*i +: 6] ^ D1[6*i +: 6];
        par[0] = par[0] ^ bad;
        // reverse meets the parity char in the low digits first
        w = '{36'h0, 36'h0, 36'hfffffffff, D0, D1,
            rev ? {30'h0, par} : {par, 30'h0}, 36'h0};
        nx = '{CODE_SYNC, CODE_PAR, CODE_DATA, CODE_DATA, CODE_PAR,
            CODE_SYNC, CODE_BN};
        #37;
        for (i = 0; i < 7; i++)
            tape_transport_model_inst.play_word(3'h3, {6'h00, nx[i]}, w[i],
                rev);
    endtask : play_block

    // block read either way, optionally with a damaged parity char
    task automatic t_read(input logic bad, input logic rev);
        int i;
        send_cmd(FN_RD_DATA, 3'h3, rev);
        got.delete();
        play_block(bad, rev);
        for (i = 0; i < 40 && got.size() < 2; i++) @(negedge clk);
        if (got.size() != 2) begin
            errors++;
            wrap_up();
        end else begin
            check("rdWord0", D0, got[0]);
            check("rdWord1", D1, got[1]);
        end
        check("parityErr", 36'(bad), parityErr);
        check("markErr", 36'h0, markErr);
        check("dataOe", 36'h0, dataOe);
    endtask : t_read

    // block write: both parity areas and the data, never the sync areas
    task automatic t_wblock;
        int n;
        send_cmd(FN_WR_DATA, 3'h3, 1'b0);
        n = oeFrames;
        play_block(1'b0, 1'b0);
        n = oeFrames - n;
        check("oeFrames", 36'(4 * FRAMES_PER_WORD), 36'(n));
        check("dataOe", 36'h0, dataOe);
        check("markErr", 36'h0, markErr);
    endtask : t_wblock

    // mark formatting: mark and timing tracks written, data wanted
    task automatic t_mark;
        int n;
        send_cmd(FN_WR_MARK, 3'h3, 1'b0);
        @(negedge clk);
        check("dataReq", 36'h1, dataReq);
        n = tmgRise;
        tape_transport_model_inst.play_word(3'h3, 12'h000, 36'h0, 1'b0);
        check("markOe", 36'h1, markOe);
        check("timingRuns", 36'h1, 36'((tmgRise - n) >= 4));
    endtask : t_mark

    // reset, then the scenarios in turn
    initial begin
        rst = 1'b0;
        cmdLoad = 1'b0;
        cmdFunc = FN_NONE;
        cmdRev = 1'b0;
        cmdUnit = 3'h0;
        wrWord = D0;
        wrValid = 1'b0;
        // a clean rising edge clears both clock domains
        #1 rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check("wrReady", 36'h1, wrReady);
        check("rdValid", 36'h0, rdValid);
        t_write();
        t_read(1'b0, 1'b0);
        t_read(1'b1, 1'b0);
        t_wblock();
        t_read(1'b0, 1'b1);
        t_mark();
        wrap_up();
    end
endmodule : tb_tape_format_ctrl
